// ===== common/sadc_pkg.sv
// Functional notes
// - Approximation resolves one bit per comparator decision, MSB first down to LSB.
// - After LSB, approximation copied to result register; this ends conversion.
// - Approximation register has no software read or write path.
// - Result occupies upper 10 bits of 16-bit result; lower 6 read zero.
// - Separate byte view returns only the upper 8 result bits.
// - With power-fail enabled, interrupt only when high byte meets threshold compare.
// - Sample-hold stays in hold for the whole conversion.
// - Analog pins not selected remain readable as digital input port pins.
// - Mode register accepts whole-byte and single-bit accesses.
// - Reset clears mode register: stopped, select mode, default timing.
// - Mode bit 7 enables conversion; register holds conversion-time fields.
// - Channel register picks the pin routed to sample-hold; in scan mode it picks only the first pin.
// - Power-fail mode register sets detection; threshold register holds compare value.
// - Select mode repeats conversions while enabled, interrupt after each one that passes the power-fail check.
package sadc_pkg;
  localparam int RES_BITS = 10;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 4;
  // Word offsets on the Avalon slave (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HI = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PF_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PF_THRESH = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_BIT_ACCESS = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_PORT_IN = 4'ha;
  // Mode register fields
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_SCAN_BIT = 6;
  localparam int MODE_FR_LSB = 3;
  localparam int MODE_HS_LSB = 1;
  localparam int MODE_BOOST_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Power-fail mode fields
  localparam int PF_EN_BIT = 7;
  localparam int PF_ABOVE_BIT = 6;
  localparam logic [7:0] PF_RESET = 8'h00;
  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam int RESULT_SHIFT = 6;
  // Bit access register: [3] value, [2:0] bit index
  localparam int BIT_VAL_POS = 3;
  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_W = 1;
  // Timing: sample time and comparator settle time per bit
  localparam int SAMPLE_NS = 1000;
  localparam int BIT_NS = 500;
  localparam int CLK_NS = 25;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic hold;
    logic [CH_W-1:0] channel;
  } sadc_front_s;

  typedef struct packed {
    logic enable;
    logic powerFailEn;
    logic powerFailAbove;
    logic [7:0] threshold;
  } sadc_pf_s;
endpackage

// ===== src/sadc_pf_check.sv
`timescale 1ns/1ps
module sadc_pf_check
  import sadc_pkg::*;
(
  input wire logic [7:0] resultHigh,
  input wire sadc_pf_s pfCfg,
  output logic irqAllowed
);
  logic aboveMatch;
  logic belowMatch;

  assign aboveMatch = resultHigh >= pfCfg.threshold;
  assign belowMatch = resultHigh < pfCfg.threshold;
  assign irqAllowed = !pfCfg.powerFailEn ||
                      (pfCfg.powerFailAbove ? aboveMatch : belowMatch);
endmodule

// ===== src/sadc_sar_core.sv
`timescale 1ns/1ps
module sadc_sar_core
  import sadc_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic step,
  input wire logic compHigh,
  output logic [WIDTH-1:0] trial,
  output logic done,
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] sar_reg;
  logic [WIDTH-1:0] mask_reg;
  logic [WIDTH-1:0] keep;
  logic busy_reg;

  // Bit under test is forced high so the DAC shows the trial level
  assign trial = sar_reg | mask_reg;
  assign keep = compHigh ? trial : sar_reg;
  assign value = keep;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sar_reg <= '0;
      mask_reg <= '0;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        sar_reg <= '0;
        mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
        busy_reg <= 1'b1;
      end else if (busy_reg && step) begin
        sar_reg <= keep;
        mask_reg <= mask_reg >> 1;
        if (mask_reg[0]) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== src/sar_adc_control.sv
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module sar_adc_control
  import sadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic compHigh,
  input wire logic [NUM_CH-1:0] pinDigitalIn,
  output logic [RES_BITS-1:0] dacLevel,
  output logic [CH_W-1:0] muxChannel,
  output logic holdEnable,
  output logic boostReferenceOn,
  output logic [NUM_CH-1:0] portInput,
  output logic conv_done_irq
);
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_STORE} sadc_state_e;

  sadc_state_e state_reg;
  logic [7:0] conversion_mode_control_reg;
  logic [CH_W-1:0] channel_select_reg;
  logic [7:0] powerfail_mode_reg;
  logic [7:0] powerfail_threshold_reg;
  logic [15:0] conversion_result_reg;
  logic [IRQ_W-1:0] irqStatus_reg;
  logic [IRQ_W-1:0] irqEnable_reg;
  logic [CH_W-1:0] convChannel_reg;
  logic [CNT_W-1:0] count_reg;
  logic [NUM_CH-1:0] pinSync1_reg;
  logic [NUM_CH-1:0] pinSync2_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;

  logic conversionEnable;
  logic scanSelect;
  logic startPulse;
  logic stepPulse;
  logic sarDone;
  logic [RES_BITS-1:0] sarTrial;
  logic [RES_BITS-1:0] sarValue;
  logic [15:0] resultNext;
  logic irqAllowed;
  logic doneEvent;
  logic countZero;
  logic wrStrobe;
  logic rdStrobe;
  logic wrMode;
  logic wrBit;
  logic wrChannel;
  logic wrPfMode;
  logic wrThresh;
  logic wrIrqEn;
  logic wrIrqClr;
  logic [7:0] modeByte;
  logic [7:0] bitUpdated;
  logic [2:0] bitIndex;
  logic [31:0] readMux;
  logic [IRQ_W-1:0] irqSet;
  logic [IRQ_W-1:0] irqClear;
  sadc_pf_s pfCfg;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic strobe,
                                  input logic lane0);
    wr_hit = strobe && lane0 && (addr == ofs);
  endfunction

  // Avalon: one wait cycle; reads sampled early, writes land on the answer edge
  assign wrStrobe = avs_write && ack_reg;
  assign rdStrobe = avs_read && !ack_reg;
  assign wrMode = wr_hit(OFS_MODE, avs_address, wrStrobe, avs_byteenable[0]);
  assign wrBit = wr_hit(OFS_BIT_ACCESS, avs_address, wrStrobe,
                        avs_byteenable[0]);
  assign wrChannel = wr_hit(OFS_CHANNEL, avs_address, wrStrobe,
                            avs_byteenable[0]);
  assign wrPfMode = wr_hit(OFS_PF_MODE, avs_address, wrStrobe,
                           avs_byteenable[0]);
  assign wrThresh = wr_hit(OFS_PF_THRESH, avs_address, wrStrobe,
                           avs_byteenable[0]);
  assign wrIrqEn = wr_hit(OFS_IRQ_ENABLE, avs_address, wrStrobe,
                          avs_byteenable[0]);
  assign wrIrqClr = wr_hit(OFS_IRQ_CLEAR, avs_address, wrStrobe,
                           avs_byteenable[0]);

  // Single-bit write: index in [2:0], value in [3]
  assign bitIndex = avs_writedata[2:0];
  assign bitUpdated = (conversion_mode_control_reg & ~(8'h01 << bitIndex)) |
                      ({7'h00, avs_writedata[BIT_VAL_POS]} << bitIndex);
  assign modeByte = wrMode ? avs_writedata[7:0] :
                    wrBit ? bitUpdated : conversion_mode_control_reg;

  assign conversionEnable = conversion_mode_control_reg[MODE_EN_BIT];
  assign scanSelect = conversion_mode_control_reg[MODE_SCAN_BIT];

  assign pfCfg = '{enable: conversionEnable,
                   powerFailEn: powerfail_mode_reg[PF_EN_BIT],
                   powerFailAbove: powerfail_mode_reg[PF_ABOVE_BIT],
                   threshold: powerfail_threshold_reg};

  // Sample/hold sequencing
  assign countZero = (count_reg == '0);
  assign startPulse = (state_reg == ST_SAMPLE) && countZero;
  assign stepPulse = (state_reg == ST_CONVERT) && countZero;
  assign resultNext = {sarValue, {RESULT_SHIFT{1'b0}}};
  assign doneEvent = (state_reg == ST_STORE) && irqAllowed;

  assign irqSet = doneEvent ? IRQ_W'(1) : '0;
  assign irqClear = wrIrqClr ? avs_writedata[IRQ_W-1:0] : '0;

  // The approximation register is absent from this map
  always_comb begin
    readMux = 32'h0000_0000;
    case (avs_address)
      OFS_MODE: readMux = {24'h000000, conversion_mode_control_reg};
      OFS_RESULT: readMux = {16'h0000, conversion_result_reg};
      OFS_RESULT_HI: readMux = {24'h000000, conversion_result_reg[15:8]};
      OFS_CHANNEL: readMux = {29'h0, channel_select_reg};
      OFS_PF_MODE: readMux = {24'h000000, powerfail_mode_reg};
      OFS_PF_THRESH: readMux = {24'h000000, powerfail_threshold_reg};
      OFS_BIT_ACCESS: readMux = {28'h0, 1'b0, 3'h0};
      OFS_IRQ_STATUS: readMux = {31'h0, irqStatus_reg};
      OFS_IRQ_ENABLE: readMux = {31'h0, irqEnable_reg};
      OFS_PORT_IN: readMux = {24'h000000, portInput};
      default: readMux = 32'h0000_0000;
    endcase
  end

  sadc_sar_core #(
    .WIDTH(RES_BITS)
  ) u_core (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(startPulse),
    .step(stepPulse),
    .compHigh(compHigh),
    .trial(sarTrial),
    .done(sarDone),
    .value(sarValue)
  );

  sadc_pf_check u_pf (
    .resultHigh(conversion_result_reg[15:8]),
    .pfCfg(pfCfg),
    .irqAllowed(irqAllowed)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
      conversion_mode_control_reg <= MODE_RESET;
      channel_select_reg <= '0;
      powerfail_mode_reg <= PF_RESET;
      powerfail_threshold_reg <= THRESH_RESET;
      irqEnable_reg <= '0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (rdStrobe) readdata_reg <= readMux;
      conversion_mode_control_reg <= modeByte;
      if (wrChannel) channel_select_reg <= avs_writedata[CH_W-1:0];
      if (wrPfMode) powerfail_mode_reg <= avs_writedata[7:0];
      if (wrThresh) powerfail_threshold_reg <= avs_writedata[7:0];
      if (wrIrqEn) irqEnable_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqStatus_reg <= '0;
      conv_done_irq <= 1'b0;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqSet;
      conv_done_irq <= |((irqStatus_reg & ~irqClear | irqSet) &
                         irqEnable_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinSync1_reg <= '0;
      pinSync2_reg <= '0;
      portInput <= '0;
    end else begin
      pinSync1_reg <= pinDigitalIn;
      pinSync2_reg <= pinSync1_reg;
      // Channel under conversion reads as zero; in scan mode the mask follows
      portInput <= pinSync2_reg &
                   ~((NUM_CH)'(conversionEnable) << convChannel_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
      convChannel_reg <= '0;
      conversion_result_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (conversionEnable) begin
            state_reg <= ST_SAMPLE;
            count_reg <= CNT_W'(SAMPLE_CYC - 1);
            convChannel_reg <= channel_select_reg;
          end
        end
        ST_SAMPLE: begin
          if (!conversionEnable) state_reg <= ST_IDLE;
          else if (countZero) begin
            state_reg <= ST_CONVERT;
            count_reg <= CNT_W'(BIT_CYC - 1);
          end else count_reg <= count_reg - 1'b1;
        end
        ST_CONVERT: begin
          // Abort on disable; a partial result is never stored
          if (!conversionEnable) state_reg <= ST_IDLE;
          else if (sarDone) begin
            conversion_result_reg <= resultNext;
            state_reg <= ST_STORE;
          end else if (countZero) count_reg <= CNT_W'(BIT_CYC - 1);
          else count_reg <= count_reg - 1'b1;
        end
        ST_STORE: begin
          state_reg <= conversionEnable ? ST_SAMPLE : ST_IDLE;
          count_reg <= CNT_W'(SAMPLE_CYC - 1);
          convChannel_reg <= scanSelect ? convChannel_reg + 1'b1
                                        : channel_select_reg;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      holdEnable <= 1'b0;
      muxChannel <= '0;
      dacLevel <= '0;
      boostReferenceOn <= 1'b0;
    end else begin
      holdEnable <= (state_reg == ST_CONVERT);
      muxChannel <= convChannel_reg;
      dacLevel <= sarTrial;
      boostReferenceOn <= conversion_mode_control_reg[MODE_BOOST_BIT];
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = readdata_reg;
endmodule

// ===== tb/sadc_analog_model.sv
`timescale 1ns/1ps
module sadc_analog_model
  import sadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_CH-1:0][RES_BITS-1:0] levels,
  input wire logic [CH_W-1:0] muxChannel,
  input wire logic holdEnable,
  input wire logic [RES_BITS-1:0] dacLevel,
  output logic compHigh
);
  logic [RES_BITS-1:0] heldLevel = '0;
  // Tracks the pin whenever holdEnable is low, so pin moves during hold cannot leak in
  always_ff @(posedge core_clk) begin
    if (!holdEnable) begin
      heldLevel <= levels[muxChannel];
    end
  end
  assign compHigh = (heldLevel >= dacLevel);
endmodule

// ===== tb/sadc_ctl_sva.sv
`timescale 1ns/1ps
module sadc_ctl_sva
  import sadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [RES_BITS-1:0] dacLevel,
  input wire logic [CH_W-1:0] muxChannel,
  input wire logic holdEnable,
  input wire logic boostReferenceOn,
  input wire logic [NUM_CH-1:0] portInput,
  input wire logic conv_done_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic rdDone;
  assign req = avs_read || avs_write;
  assign rdDone = avs_read && !avs_waitrequest;
  sequence reqStart;
    req && !$past(req);
  endsequence
  sequence answerNext;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  chk_wait_one: assert property (reqStart |-> answerNext)
    else $error("waitrequest not one cycle");
  chk_hold_steady: assert property (holdEnable && $past(holdEnable)
    |-> $stable(muxChannel)) else $error("channel moved during hold");
  chk_hold_min: assert property ($rose(holdEnable) |-> holdEnable[*8])
    else $error("hold dropped early");
  chk_msb_first: assert property ($rose(holdEnable)
    |-> ##[0:2] (dacLevel == 10'h200)) else $error("first trial not msb");
  chk_result_zeros: assert property (rdDone && avs_address == OFS_RESULT
    |-> avs_readdata[5:0] == 6'h00 && avs_readdata[31:16] == 16'h0000)
    else $error("result low bits not zero");
  chk_high_byte: assert property (rdDone && avs_address == OFS_RESULT_HI
    |-> avs_readdata[31:8] == 24'h000000) else $error("high view too wide");
  chk_unmapped_zero: assert property (rdDone && avs_address > OFS_PORT_IN
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  chk_pin_masked: assert property (holdEnable
    |-> portInput[muxChannel] == 1'b0) else $error("analog pin not masked");
  chk_reset_quiet: assert property ($rose(rst_n)
    |-> !holdEnable && !boostReferenceOn && !conv_done_irq)
    else $error("outputs active after reset");
endmodule
bind sar_adc_control sadc_ctl_sva u_sva (.core_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .dacLevel,
  .muxChannel, .holdEnable, .boostReferenceOn, .portInput, .conv_done_irq);

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
  import sadc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic compHigh;
  logic [NUM_CH-1:0] pinDigitalIn = 8'hff;
  logic [NUM_CH-1:0][RES_BITS-1:0] levels = {8{10'h2a5}};
  logic [RES_BITS-1:0] dacLevel;
  logic [CH_W-1:0] muxChannel;
  logic holdEnable;
  logic boostReferenceOn;
  logic [NUM_CH-1:0] portInput;
  logic conv_done_irq;
  logic [31:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  sar_adc_control u_dut (.core_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .compHigh, .pinDigitalIn, .dacLevel, .muxChannel,
    .holdEnable, .boostReferenceOn, .portInput, .conv_done_irq);
  sadc_analog_model u_ana (.core_clk, .levels, .muxChannel, .holdEnable,
    .dacLevel, .compHigh);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waitrequest and readdata are taken at the rising edge that ends the wait
  task automatic acc(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] be);
    bit got;
    got = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) begin
        got = 1;
        rd = avs_readdata;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!got) begin
      check("bus answer", 32'h1, 32'h0);
      results();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    acc(a, 1'b1, d, 4'h1);
  endtask
  task automatic rdchk(string what, logic [ADDR_W-1:0] a, logic [31:0] e);
    acc(a, 1'b0, 32'h0, 4'hf);
    check(what, e, rd);
  endtask
  task automatic wirq(input int n, input logic e);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge core_clk);
      seen = (conv_done_irq === 1'b1);
    end
    check("irq", {31'h0, e}, {31'h0, seen});
  endtask
  task automatic whold();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 600 && !seen; i++) begin
      @(negedge core_clk);
      seen = (holdEnable === 1'b1);
    end
    check("hold", 32'h1, {31'h0, seen});
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk("mode", OFS_MODE, 32'h0);
    rdchk("threshold", OFS_PF_THRESH, 32'h0);
    $display("test reset done");
    wr(OFS_MODE, 32'h01);
    repeat (2) @(negedge core_clk);
    check("boost", 32'h1, {31'h0, boostReferenceOn});
    wr(OFS_BIT_ACCESS, 32'h0);
    rdchk("mode bit", OFS_MODE, 32'h0);
    acc(OFS_CHANNEL, 1'b1, 32'h6, 4'h0);
    rdchk("channel", OFS_CHANNEL, 32'h0);
    rdchk("unmapped", 4'hf, 32'h0);
    $display("test registers done");
    wr(OFS_CHANNEL, 32'h5);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_BIT_ACCESS, 32'hf);
    wirq(2000, 1'b1);
    rdchk("result", OFS_RESULT, 32'ha940);
    rdchk("result high", OFS_RESULT_HI, 32'ha9);
    check("mux", 32'h5, {29'h0, muxChannel});
    check("port", 32'hdf, {24'h0, portInput});
    rdchk("status", OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    wirq(600, 1'b0);
    rdchk("masked status", OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wirq(4, 1'b1);
    $display("test conversion done");
    wr(OFS_PF_THRESH, 32'hb0);
    wr(OFS_PF_MODE, 32'hc0);
    wr(OFS_IRQ_CLEAR, 32'h1);
    wirq(600, 1'b0);
    rdchk("pf status", OFS_IRQ_STATUS, 32'h0);
    wr(OFS_PF_MODE, 32'h80);
    wirq(600, 1'b1);
    $display("test power fail done");
    levels[5] <= 10'h0ff;
    wr(OFS_PF_MODE, 32'h0);
    repeat (2) begin
      wr(OFS_IRQ_CLEAR, 32'h1);
      wirq(600, 1'b1);
    end
    rdchk("new result", OFS_RESULT, 32'h3fc0);
    wr(OFS_IRQ_CLEAR, 32'h1);
    whold();
    // A pin move during hold must not reach the running conversion
    levels[5] <= 10'h3ff;
    wirq(600, 1'b1);
    rdchk("held result", OFS_RESULT, 32'h3fc0);
    $display("test repeat done");
    levels[6] <= 10'h100;
    wr(OFS_MODE, 32'hc0);
    repeat (2) begin
      wr(OFS_IRQ_CLEAR, 32'h1);
      wirq(600, 1'b1);
    end
    rdchk("scan result", OFS_RESULT, 32'h4000);
    check("scan mux", 32'h7, {29'h0, muxChannel});
    check("scan port", 32'h7f, {24'h0, portInput});
    $display("test scan done");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk("mode after reset", OFS_MODE, 32'h0);
    rdchk("result after reset", OFS_RESULT, 32'h0);
    check("hold after reset", 32'h0, {31'h0, holdEnable});
    $display("test mid reset done");
    results();
  end
endmodule
